// [logic/lrm_monitor.sv]
// Purpose: link error-rate monitor with APB register access
// Assumes: event inputs come from logic on core_clk, one-cycle pulses
// Notes: rst clears everything; nonStickyRst clears only counters
//
// The APB register port is this design's own decision.
`default_nettype none

// Operation
// R1: 8-bit error threshold, default all ones, sticky
// R2: software never programs zero threshold or window
// R3: 24-bit microsecond window in upper threshold bits
// R4: unreliable when window error count reaches threshold
// R5: 8-bit error counter counts errors, saturates
// R6: 24-bit window counter saturates, never wraps
// R7: window counter advances once per microsecond
// R8: error counter clears on retrain or link down
// R9: window counter clears on retrain or full retrain
// R10: both counters clear on enable rising edge
// R11: counters freeze once link judged unreliable
// R12: window expiry restarts the error counter
// R13: window expiry restarts the window counter
// R14: counters keep running while monitor disabled
// R15: flag raised when errors reach threshold
// R16: flag only set while enable is set
// R17: hardware never clears flag; write one clears
// R18: type select picks CRC or recovery errors
// R19: microsecond tick from fixed core-clock prescaler
// R20: resets beat freeze, freeze beats window restart
module lrm_monitor
    import lrm_pkg::*;
#(
    parameter int TICK_CYCLES = LRM_TICK_CYCLES // core cycles per microsecond
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic nonStickyRst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // link-side events
    input wire logic linkRetrainBit,
    input wire logic dataLinkDown,
    input wire logic fullRetrainDetect,
    input wire logic crcError,
    input wire logic recoveryEntry,
    // status out
    output logic unreliableLinkFlag
);

    // register decode, used for both read and write
    function automatic logic [3:0] decodeReg(input logic [15:0] addr);
        decodeReg = {addr == LRM_OFF_THRESHOLD, addr == LRM_OFF_COUNTERS,
                     addr == LRM_OFF_STATUS, addr == LRM_OFF_CONTROL};
    endfunction : decodeReg

    // sticky settings
    logic monitorEnable; // monitor_control enable bit
    logic errorTypeSel; // monitor_control type bit
    logic [7:0] errorThreshold; // error_threshold field
    logic [23:0] windowLength; // monitoring window in microseconds
    // live state
    logic [7:0] errorCounter; // errors counted in this window
    logic [23:0] windowCounter; // microseconds elapsed in this window
    logic enablePrev; // enable one cycle ago, for edge detect
    logic usTick; // one-cycle microsecond enable

    // bus decode wires
    wire logic [3:0] regHit = decodeReg(paddr);
    wire logic hitControl = regHit[0];
    wire logic hitStatus = regHit[1];
    wire logic hitCounters = regHit[2];
    wire logic hitThreshold = regHit[3];
    wire logic anyHit = |regHit;
    wire logic setupPhase = psel && !penable;
    wire logic accessPhase = psel && penable;
    wire logic writeStrobe = accessPhase && pwrite && anyHit;
    wire logic flagClearWrite = writeStrobe && hitStatus && pwdata[LRM_STS_FLAG_BIT];

    // counter control terms
    wire logic enableRise = monitorEnable && !enablePrev;
    wire logic errorClear = linkRetrainBit || dataLinkDown || enableRise || nonStickyRst;
    wire logic windowClear = linkRetrainBit || fullRetrainDetect || enableRise
                             || nonStickyRst;
    wire logic thresholdReached = (errorCounter >= errorThreshold);
    wire logic unreliableNow = monitorEnable && thresholdReached;
    wire logic windowExpired = (windowCounter == windowLength);
    wire logic errorEvent = (errorTypeSel == LRM_TYPE_RECOVERY) ? recoveryEntry : crcError;

    // next-value wires
    logic [7:0] next_errorCounter;
    logic [23:0] next_windowCounter;
    logic next_flag;
    logic [31:0] next_prdata;

    // microsecond prescaler
    lrm_us_tick #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .core_clk(core_clk),
        .rst(rst),
        .usTick(usTick)
    );

    // error counter next value in priority order
    always_comb begin
        if (errorClear) begin
            next_errorCounter = '0; // R8 R10 R20
        end else if (unreliableNow) begin
            next_errorCounter = errorCounter; // R11 R20
        end else if (windowExpired) begin
            next_errorCounter = '0; // R12
        end else if (errorEvent && errorCounter != LRM_ERR_MAX) begin
            // runs whether or not the monitor is enabled
            next_errorCounter = errorCounter + 8'h01; // R5 R14 R18
        end else begin
            next_errorCounter = errorCounter; // R5
        end
    end

    // window counter next value in priority order
    always_comb begin
        if (windowClear) begin
            next_windowCounter = '0; // R9 R10 R20
        end else if (unreliableNow) begin
            next_windowCounter = windowCounter; // R11 R20
        end else if (windowExpired) begin
            next_windowCounter = '0; // R13
        end else if (usTick && windowCounter != LRM_WIN_MAX) begin
            next_windowCounter = windowCounter + 24'h000001; // R6 R7 R14
        end else begin
            next_windowCounter = windowCounter; // R6
        end
    end

    // flag: set wins over the write-one clear, hardware never clears it
    always_comb begin
        next_flag = (unreliableLinkFlag && !flagClearWrite) || unreliableNow; // R4 R15 R16 R17
    end

    // read mux, sampled in setup so prdata is a flop by the access phase
    always_comb begin
        next_prdata = '0;
        if (hitControl) begin
            next_prdata[LRM_CTL_EN_BIT] = monitorEnable;
            next_prdata[LRM_CTL_TYPE_BIT] = errorTypeSel;
        end else if (hitStatus) begin
            next_prdata[LRM_STS_FLAG_BIT] = unreliableLinkFlag;
        end else if (hitCounters) begin
            next_prdata = {windowCounter, errorCounter};
        end else if (hitThreshold) begin
            next_prdata = {windowLength, errorThreshold};
        end
    end

    // sticky settings: only the full reset touches them
    always_ff @(posedge core_clk) begin
        if (rst) begin
            monitorEnable <= 1'b0;
            errorTypeSel <= LRM_TYPE_CRC;
        end else if (writeStrobe && hitControl) begin
            monitorEnable <= pwdata[LRM_CTL_EN_BIT];
            errorTypeSel <= pwdata[LRM_CTL_TYPE_BIT]; // R18
        end
    end

    // threshold register; zero values are the programmer's problem
    always_ff @(posedge core_clk) begin
        if (rst) begin
            errorThreshold <= LRM_THR_RESET; // R1
            windowLength <= LRM_WIN_RESET; // R3
        end else if (writeStrobe && hitThreshold) begin
            errorThreshold <= pwdata[LRM_THR_LSB +: LRM_THR_W]; // R1 R2
            windowLength <= pwdata[LRM_WIN_LSB +: LRM_WIN_W]; // R3 R2
        end
    end

    // enable history for the rising-edge clear
    always_ff @(posedge core_clk) begin
        if (rst) begin
            enablePrev <= 1'b0;
        end else begin
            enablePrev <= monitorEnable; // R10
        end
    end

    // counters
    always_ff @(posedge core_clk) begin
        if (rst) begin
            errorCounter <= '0;
            windowCounter <= '0;
        end else begin
            errorCounter <= next_errorCounter;
            windowCounter <= next_windowCounter;
        end
    end

    // sticky status flag
    always_ff @(posedge core_clk) begin
        if (rst) begin
            unreliableLinkFlag <= 1'b0;
        end else begin
            unreliableLinkFlag <= next_flag; // R17
        end
    end

    // read data register, loaded in the setup cycle only
    always_ff @(posedge core_clk) begin
        if (rst) begin
            prdata <= '0;
        end else if (setupPhase) begin
            prdata <= next_prdata;
        end
    end

    // zero wait states; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = accessPhase && !anyHit;

    // ---------------- assertions ----------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    // helper: no counter clear of any kind this cycle
    wire logic noClear = !errorClear && !windowClear;

    property p_flag_needs_enable;
        $rose(unreliableLinkFlag) |-> $past(monitorEnable);
    endproperty
    a_flag_needs_enable: assert property (p_flag_needs_enable) // R16
        else $error("flag rose while monitor disabled");

    property p_flag_on_threshold;
        monitorEnable && (errorCounter >= errorThreshold) |=> unreliableLinkFlag;
    endproperty
    a_flag_on_threshold: assert property (p_flag_on_threshold) // R15
        else $error("flag missed with errors at threshold");

    property p_flag_held;
        unreliableLinkFlag && !flagClearWrite |=> unreliableLinkFlag;
    endproperty
    a_flag_held: assert property (p_flag_held) // R17
        else $error("flag cleared without software write");

    property p_err_saturates;
        errorCounter == LRM_ERR_MAX && noClear && !windowExpired |=> errorCounter == LRM_ERR_MAX;
    endproperty
    a_err_saturates: assert property (p_err_saturates) // R5
        else $error("error counter wrapped");

    property p_err_counts;
        errorEvent && noClear && !unreliableNow && !windowExpired
            && errorCounter != LRM_ERR_MAX |=> errorCounter == $past(errorCounter) + 8'h01;
    endproperty
    a_err_counts: assert property (p_err_counts) // R5
        else $error("error not counted");

    property p_win_tick;
        usTick && noClear && !unreliableNow && !windowExpired && windowCounter != LRM_WIN_MAX
            |=> windowCounter == $past(windowCounter) + 24'h000001;
    endproperty
    a_win_tick: assert property (p_win_tick) // R7
        else $error("window counter missed a tick");

    property p_win_no_tick;
        !usTick && noClear && !windowExpired |=> $stable(windowCounter);
    endproperty
    a_win_no_tick: assert property (p_win_no_tick) // R7
        else $error("window counter moved without tick");

    property p_err_clear;
        linkRetrainBit || dataLinkDown |=> errorCounter == 8'h00;
    endproperty
    a_err_clear: assert property (p_err_clear) // R8
        else $error("error counter not cleared by link event");

    property p_win_clear;
        linkRetrainBit || fullRetrainDetect |=> windowCounter == 24'h000000;
    endproperty
    a_win_clear: assert property (p_win_clear) // R9
        else $error("window counter not cleared by retrain");

    property p_enable_rise;
        $rose(monitorEnable) |=> errorCounter == 8'h00 && windowCounter == 24'h000000;
    endproperty
    a_enable_rise: assert property (p_enable_rise) // R10
        else $error("counters not cleared on enable");

    property p_freeze;
        unreliableNow && noClear |=> $stable(errorCounter) && $stable(windowCounter);
    endproperty
    a_freeze: assert property (p_freeze) // R11
        else $error("counters moved after unreliable decision");

    property p_window_restart;
        windowExpired && noClear && !unreliableNow
            |=> windowCounter == 24'h000000 && errorCounter == 8'h00;
    endproperty
    a_window_restart: assert property (p_window_restart) // R12
        else $error("window expiry did not restart counters");

    property p_tick_spacing;
        usTick |=> !usTick [*8];
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) // R19
        else $error("microsecond ticks too close");

    // window saturation is only reachable after a length shorter than the count
    property p_win_saturates;
        windowCounter == LRM_WIN_MAX && noClear && !windowExpired |=> windowCounter == LRM_WIN_MAX;
    endproperty
    a_win_saturates: assert property (p_win_saturates) // R6
        else $error("window counter wrapped");

    property p_flag_w1c;
        unreliableLinkFlag && flagClearWrite && !unreliableNow |=> !unreliableLinkFlag;
    endproperty
    a_flag_w1c: assert property (p_flag_w1c) // R17
        else $error("write one did not clear the flag");

    property p_nonsticky_clear;
        nonStickyRst |=> errorCounter == 8'h00 && windowCounter == 24'h000000;
    endproperty
    a_nonsticky_clear: assert property (p_nonsticky_clear)
        else $error("counters not cleared by non-sticky reset");

    property p_type_select;
        errorTypeSel == LRM_TYPE_CRC && recoveryEntry && !crcError && noClear && !windowExpired
            |=> errorCounter == $past(errorCounter);
    endproperty
    a_type_select: assert property (p_type_select) // R18
        else $error("recovery entry counted in crc mode");

    c_flag_set: cover property (!unreliableLinkFlag ##1 unreliableLinkFlag);
    c_flag_cleared: cover property (unreliableLinkFlag && flagClearWrite ##1 !unreliableLinkFlag);
    c_window_expiry: cover property (windowExpired && noClear && !unreliableNow);
    c_recovery_count: cover property (errorTypeSel && recoveryEntry && noClear);
    c_err_saturated: cover property (errorCounter == LRM_ERR_MAX);

endmodule : lrm_monitor

`default_nettype wire

// [logic/lrm_pkg.sv]
// Purpose: shared constants of the link error-rate monitor
// Assumes: 100 MHz core clock, 32-bit APB register bus
// Notes: offsets are byte addresses on the APB word bus
`default_nettype none

package lrm_pkg;

    // register byte offsets
    localparam logic [15:0] LRM_OFF_CONTROL = 16'h0560; // monitor_control_register
    localparam logic [15:0] LRM_OFF_STATUS = 16'h0564; // unreliable_link_flag lives here
    localparam logic [15:0] LRM_OFF_COUNTERS = 16'h056C; // link_reliability_counters
    localparam logic [15:0] LRM_OFF_THRESHOLD = 16'h5680; // link_reliability_threshold

    // monitor_control field positions
    localparam int LRM_CTL_EN_BIT = 0; // monitor enable
    localparam int LRM_CTL_TYPE_BIT = 1; // error type select
    // status field position
    localparam int LRM_STS_FLAG_BIT = 0; // unreliable_link_flag, write one to clear

    // threshold register layout
    localparam int LRM_THR_LSB = 0;
    localparam int LRM_THR_W = 8;
    localparam int LRM_WIN_LSB = 8;
    localparam int LRM_WIN_W = 24;

    // reset values of the sticky settings and counter saturation limits
    localparam logic [7:0] LRM_THR_RESET = 8'hFF;
    localparam logic [23:0] LRM_WIN_RESET = 24'hFFFFFF;
    localparam logic [7:0] LRM_ERR_MAX = 8'hFF;
    localparam logic [23:0] LRM_WIN_MAX = 24'hFFFFFF;

    // error type encodings
    localparam logic LRM_TYPE_CRC = 1'b0; // individual link CRC errors
    localparam logic LRM_TYPE_RECOVERY = 1'b1; // local L0 to Recovery entries

    // microsecond tick timing
    localparam int LRM_CLK_PERIOD_PS = 10000; // core clock period
    localparam int LRM_TICK_PERIOD_US = 1; // window counter unit
    localparam int LRM_TICK_CYCLES = (LRM_TICK_PERIOD_US * 1000000) / LRM_CLK_PERIOD_PS;

endpackage : lrm_pkg

`default_nettype wire

// [logic/lrm_us_tick.sv]
// Purpose: one-cycle enable pulse once per microsecond
// Assumes: free-running core clock at the package rate
// Notes: the count depends on the core clock only, never on the link rate
`default_nettype none

module lrm_us_tick
    import lrm_pkg::*;
#(
    parameter int TICK_CYCLES = LRM_TICK_CYCLES // core cycles per microsecond
) (
    input wire logic core_clk,
    input wire logic rst,
    output logic usTick
);

    localparam int CW = $clog2(TICK_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

    logic [CW-1:0] divCnt; // cycles elapsed in the current microsecond
    wire divWrap = (divCnt == LAST); // last cycle of the microsecond

    // prescaler counts up through the fixed period and restarts
    always_ff @(posedge core_clk) begin
        if (rst) begin
            divCnt <= '0;
        end else if (divWrap) begin
            divCnt <= '0; // R19
        end else begin
            divCnt <= divCnt + CW'(1);
        end
    end

    // registered so the tick is a clean single-cycle enable
    always_ff @(posedge core_clk) begin
        if (rst) begin
            usTick <= 1'b0;
        end else begin
            usTick <= divWrap; // R19
        end
    end

endmodule : lrm_us_tick

`default_nettype wire

// [test/lrm_monitor_bench.sv]
// Purpose: self-checking bench of the link error-rate monitor over apb
// Assumes: zero-wait apb slave, tick prescaler shortened to ten cycles
// Notes: prints only mismatches and the verdict
`default_nettype none

module lrm_monitor_bench
    import lrm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int TICKS = 10; // short microsecond keeps windows brief
    logic core_clk, rst, nonStickyRst; // clock and resets
    logic psel, penable, pwrite; // apb strobes
    logic [15:0] paddr; // apb address
    logic [31:0] pwdata, prdata; // apb data
    logic pready, pslverr, unreliableLinkFlag; // slave answers
    logic linkRetrainBit, dataLinkDown, fullRetrainDetect; // clear sources
    logic crcError, recoveryEntry; // error events
    int failCount = 0; // mismatches
    int checked = 0; // comparisons made
    logic [31:0] rdData, first; // last read word, earlier sample
    logic lastErr; // pslverr seen with the last answer

    lrm_monitor #(.TICK_CYCLES(TICKS)) dut (
        .core_clk(core_clk), .rst(rst), .nonStickyRst(nonStickyRst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .linkRetrainBit(linkRetrainBit), .dataLinkDown(dataLinkDown),
        .fullRetrainDetect(fullRetrainDetect), .crcError(crcError),
        .recoveryEntry(recoveryEntry), .unreliableLinkFlag(unreliableLinkFlag)
    );

    // free-running 100 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // one apb transfer; an idle edge first so psel is never set twice in a step
    task automatic xfer(input logic wr, input logic [15:0] addr, input logic [31:0] wd);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        // no fixed latency assumed: the watchdog bounds this wait
        while (pready !== 1'b1) @(posedge core_clk);
        rdData = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    // compare and count
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            failCount++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // n one-cycle event pulses; kind bits: crc, recovery, link down, full retrain
    task automatic ev(input int n, input logic [3:0] kind);
        repeat (n) begin
            @(posedge core_clk);
            crcError <= kind[0];
            recoveryEntry <= kind[1];
            dataLinkDown <= kind[2];
            fullRetrainDetect <= kind[3];
            @(posedge core_clk);
            crcError <= 1'b0;
            recoveryEntry <= 1'b0;
            dataLinkDown <= 1'b0;
            fullRetrainDetect <= 1'b0;
        end
    endtask : ev

    // two counter samples exactly 100 cycles (ten ticks) apart
    task automatic gap();
        xfer(1'b0, LRM_OFF_COUNTERS, 32'h0);
        first = rdData;
        repeat (97) @(posedge core_clk);
        xfer(1'b0, LRM_OFF_COUNTERS, 32'h0);
    endtask : gap

    // verdict and end of run
    task automatic endSim();
        if (failCount == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : endSim

    // watchdog: the tests need well under 5000 cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        failCount++;
        endSim();
    end

    initial begin
        {rst, nonStickyRst, psel, penable, pwrite} = 5'h1F;
        {psel, penable, pwrite} = 3'h0;
        nonStickyRst = 1'b0;
        paddr = 16'h0000;
        pwdata = 32'h0;
        {linkRetrainBit, dataLinkDown, fullRetrainDetect, crcError, recoveryEntry} = 5'h00;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        // reset values, read-only counters, unmapped place
        xfer(1'b0, LRM_OFF_COUNTERS, 32'h0);
        chk("counters reset", 32'h0, rdData);
        xfer(1'b0, LRM_OFF_THRESHOLD, 32'h0);
        chk("threshold reset", {LRM_WIN_RESET, LRM_THR_RESET}, rdData);
        xfer(1'b1, LRM_OFF_COUNTERS, 32'hFFFFFFFF);
        xfer(1'b0, LRM_OFF_COUNTERS, 32'h0);
        chk("counters ro", 32'h0, {24'h0, rdData[7:0]});
        xfer(1'b0, 16'h0570, 32'h0);
        chk("unmapped data", 32'h0, rdData);
        chk("unmapped err", 32'h1, {31'h0, lastErr});
        // disabled, recovery type: counts run, flag stays low
        xfer(1'b1, LRM_OFF_THRESHOLD, 32'h00FFFF02);
        xfer(1'b0, LRM_OFF_THRESHOLD, 32'h0);
        chk("threshold rw", 32'h00FFFF02, rdData);
        xfer(1'b1, LRM_OFF_CONTROL, 32'h00000002);
        ev(1, 4'h2);
        ev(2, 4'h1);
        gap();
        chk("recovery count", 32'h1, {24'h0, rdData[7:0]});
        chk("window rate", 32'hA, {8'h0, rdData[31:8] - first[31:8]});
        chk("flag disabled", 32'h0, {31'h0, unreliableLinkFlag});
        // enable rise clears, then crc errors reach the threshold
        xfer(1'b1, LRM_OFF_CONTROL, 32'h00000001);
        xfer(1'b0, LRM_OFF_COUNTERS, 32'h0);
        chk("rise clear err", 32'h0, {24'h0, rdData[7:0]});
        chk("rise clear win", 32'h1, {31'h0, rdData[31:8] < 24'd2});
        ev(1, 4'h2);
        ev(2, 4'h1);
        ev(3, 4'h1);
        gap();
        chk("frozen err", 32'h2, {24'h0, rdData[7:0]});
        chk("frozen win", first, rdData);
        chk("flag set", 32'h1, {31'h0, unreliableLinkFlag});
        xfer(1'b0, LRM_OFF_STATUS, 32'h0);
        chk("status set", 32'h1, rdData);
        // a clear source beats the freeze
        @(posedge core_clk);
        linkRetrainBit <= 1'b1;
        xfer(1'b0, LRM_OFF_COUNTERS, 32'h0);
        chk("retrain clear", 32'h0, rdData);
        linkRetrainBit <= 1'b0;
        chk("flag kept", 32'h1, {31'h0, unreliableLinkFlag});
        // write one clears once disabled
        xfer(1'b1, LRM_OFF_CONTROL, 32'h0);
        xfer(1'b1, LRM_OFF_STATUS, 32'h1);
        xfer(1'b0, LRM_OFF_STATUS, 32'h0);
        chk("status w1c", 32'h0, rdData);
        ev(3, 4'h1);
        chk("no flag off", 32'h0, {31'h0, unreliableLinkFlag});
        // window of five microseconds restarts both counters
        xfer(1'b1, LRM_OFF_THRESHOLD, 32'h000005FF);
        xfer(1'b1, LRM_OFF_CONTROL, 32'h1);
        ev(1, 4'h1);
        gap();
        chk("expiry err", 32'h0, {24'h0, rdData[7:0]});
        chk("expiry win", 32'h1, {31'h0, rdData[31:8] <= 24'd5});
        // link down clears errors only, full retrain the window only
        xfer(1'b1, LRM_OFF_THRESHOLD, 32'hFFFFFFFF);
        ev(3, 4'h1);
        repeat (40) @(posedge core_clk);
        ev(1, 4'h4);
        xfer(1'b0, LRM_OFF_COUNTERS, 32'h0);
        chk("link down err", 32'h0, {24'h0, rdData[7:0]});
        chk("link down win", 32'h1, {31'h0, rdData[31:8] != 24'd0});
        ev(2, 4'h1);
        ev(1, 4'h8);
        xfer(1'b0, LRM_OFF_COUNTERS, 32'h0);
        chk("full retrain err", 32'h2, {24'h0, rdData[7:0]});
        chk("full retrain win", 32'h1, {31'h0, rdData[31:8] < 24'd2});
        // non-sticky reset clears counters, keeps settings
        @(posedge core_clk);
        nonStickyRst <= 1'b1;
        @(posedge core_clk);
        nonStickyRst <= 1'b0;
        xfer(1'b0, LRM_OFF_COUNTERS, 32'h0);
        chk("nonsticky err", 32'h0, {24'h0, rdData[7:0]});
        xfer(1'b0, LRM_OFF_THRESHOLD, 32'h0);
        chk("sticky threshold", 32'hFFFFFFFF, rdData);
        // reserved control bits read zero; error count saturates
        xfer(1'b1, LRM_OFF_CONTROL, 32'hFFFFFFFC);
        xfer(1'b0, LRM_OFF_CONTROL, 32'h0);
        chk("control reserved", 32'h0, rdData);
        ev(260, 4'h1);
        xfer(1'b0, LRM_OFF_COUNTERS, 32'h0);
        chk("err saturate", {24'h0, LRM_ERR_MAX}, {24'h0, rdData[7:0]});
        endSim();
    end

endmodule : lrm_monitor_bench

`default_nettype wire
